/* File: src/cam_fmt_cfg.svh */
// Offsets, field positions, reset values and timing counts of the video formatter
`ifndef CAM_FMT_CFG_SVH
`define CAM_FMT_CFG_SVH
`define A_CTRL 8'h00
`define A_WIN_H 8'h04
`define A_WIN_V 8'h08
`define A_STAT 8'h0C
`define CTRL_MSB 9
`define SIZE_LSB 16
`define ARR_W 10'h164
`define ARR_H 10'h124
`define MIN_WIN 10'h002
`define RST_HS 10'h002
`define RST_VS 10'h002
`define RST_W 10'h160
`define RST_H 10'h120
`define H_TOTAL 10'h1A4
`define V_TOTAL 10'h138
`define VS_FIRST 10'h12C
`define VS_LAST 10'h12F
`define HS_FIRST 10'h172
`define HS_LAST 10'h192
`define PIX_MIN 8'h01
`define PIX_MAX 8'hFE
`define BLANK_Y 8'h10
`define BLANK_UV 8'h80
`define CLK_NS 10
`define PIX_NS 160
`define BASE_DIV (`PIX_NS / `CLK_NS)
`endif

/* File: src/cam_fmt_pkg.sv */
// Types shared by the video output formatter
package cam_fmt_pkg;
   typedef enum logic [2:0] {
      F_YUV16 = 3'h0,
      F_YUV8 = 3'h1,
      F_RGB8 = 3'h3,
      F_RGB656 = 3'h2,
      F_RGB16 = 3'h6,
      F_NIB = 3'h7,
      F_RGBNIB = 3'h5
   } fmt_e;
   typedef struct packed {
      logic mode_ygl;
      logic rev;
      logic yus;
      logic uvs;
      logic wide;
      logic quarter_resolution_mode;
      logic bw;
      fmt_e fmt;
   } ctrl_s;
   typedef struct packed {
      logic [9:0] st;
      logic [9:0] sz;
   } span_s;
   typedef struct packed {
      logic [7:0] y;
      logic [7:0] u;
      logic [7:0] v;
   } pix_s;
endpackage

/* File: src/cam_video_formatter.sv */
// Video output formatter of the camera with its AHB-Lite configuration slave
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cam_fmt_cfg.svh"
module cam_video_formatter
   import cam_fmt_pkg::*;
#(
   parameter int BASE_DIV = `BASE_DIV,
   parameter logic [9:0] H_TOTAL = `H_TOTAL,
   parameter logic [9:0] V_TOTAL = `V_TOTAL
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire pix_s pix_i,
   output logic pix_req,
   output logic pclk,
   output logic [7:0] y_o,
   output logic y_oe,
   output logic [7:0] uv_o,
   output logic uv_oe,
   output logic line_valid,
   output logic vsync,
   output logic composite_line_sync,
   output logic odd_field_flag
);
   localparam int SH = $clog2(BASE_DIV);
   localparam int SL1 = BASE_DIV / 2;
   localparam logic [SH-1:0] DIVM = SH'(BASE_DIV - 1);

   ctrl_s ctrl_q;
   span_s hwin_q, vwin_q;
   logic wr_q;
   logic [7:0] wa_q;
   logic [31:0] rdata_q;
   logic take;
   logic [SH-1:0] div_q;
   logic [9:0] h_q, v_q;
   logic odd_q;
   pix_s cur_q;

   function automatic span_s fit(input logic [9:0] s, input logic [9:0] w, input logic [9:0] lim);
      span_s r;
      r.st = (s > lim - `MIN_WIN) ? lim - `MIN_WIN : s;
      r.sz = (w < `MIN_WIN) ? `MIN_WIN : ((w > lim - r.st) ? lim - r.st : w);
      return r;
   endfunction

   function automatic logic [7:0] clip(input logic [7:0] b);
      clip = (b < `PIX_MIN) ? `PIX_MIN : ((b > `PIX_MAX) ? `PIX_MAX : b);
   endfunction

   // AHB-Lite slave: zero wait, always OKAY, unmapped reads zero
   assign take = hsel & htrans[1] & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= take & hwrite;
         wa_q <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= '0;
         hwin_q <= '{st: `RST_HS, sz: `RST_W};
         vwin_q <= '{st: `RST_VS, sz: `RST_H};
      end else if (wr_q) begin
         unique case (wa_q)
            `A_CTRL: ctrl_q <= ctrl_s'(hwdata[`CTRL_MSB:0]);
            // Writes are forced into the array so the window logic never wraps
            `A_WIN_H: hwin_q <= fit(hwdata[9:0], hwdata[`SIZE_LSB +: 10], `ARR_W);
            `A_WIN_V: vwin_q <= fit(hwdata[9:0], hwdata[`SIZE_LSB +: 10], `ARR_H);
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (take & !hwrite) begin
         unique case (haddr[7:0])
            `A_CTRL: rdata_q <= {22'h00_0000, ctrl_q};
            `A_WIN_H: rdata_q <= {6'h00, hwin_q.sz, 6'h00, hwin_q.st};
            `A_WIN_V: rdata_q <= {6'h00, vwin_q.sz, 6'h00, vwin_q.st};
            `A_STAT: rdata_q <= {6'h00, v_q, 6'h00, h_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   assign hrdata = rdata_q;

   // Raster counters run from hclk alone, so window settings cannot touch rates
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= '0;
         h_q <= 10'h000;
         v_q <= 10'h000;
      end else begin
         div_q <= (div_q == DIVM) ? '0 : div_q + 1'b1;
         if (div_q == DIVM) begin
            h_q <= (h_q == H_TOTAL - 10'h001) ? 10'h000 : h_q + 10'h001;
            if (h_q == H_TOTAL - 10'h001) begin
               v_q <= (v_q == V_TOTAL - 10'h001) ? 10'h000 : v_q + 10'h001;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         odd_q <= 1'b0;
      end else if (div_q == '0 && h_q == 10'h000 && v_q == 10'h000) begin
         odd_q <= ~odd_q;
      end
   end

   // Mode decode and slot timing
   logic rgb, nib, eight, uv16, wide2;
   logic [1:0] slog;
   logic [3:0] lg;
   logic [SH:0] pcnt, mask, off, half;
   logic [1:0] k;
   logic sst, rise, pst, par;

   always_comb begin
      rgb = ctrl_q.fmt inside {F_RGB16, F_RGB8, F_RGB656, F_RGBNIB};
      nib = ctrl_q.fmt inside {F_NIB, F_RGBNIB};
      eight = ctrl_q.fmt inside {F_YUV8, F_RGB8, F_RGB656};
      uv16 = !ctrl_q.bw && (ctrl_q.fmt inside {F_YUV16, F_RGB16});
      wide2 = uv16 && ctrl_q.wide;
      if (nib) begin
         slog = ctrl_q.bw ? 2'd1 : 2'd2;
      end else if ((eight && !ctrl_q.bw) || wide2) begin
         slog = 2'd1;
      end else begin
         slog = 2'd0;
      end
      lg = 4'(SH) + {3'b000, ctrl_q.quarter_resolution_mode} - {2'b00, slog};
      pcnt = ctrl_q.quarter_resolution_mode ? {h_q[0], div_q} : {1'b0, div_q};
      mask = (SH+1)'((1 << lg) - 1);
      half = (SH+1)'(1 << (lg - 4'd1));
      off = pcnt & mask;
      k = 2'(pcnt >> lg);
      sst = off == '0;
      rise = off == half;
      pst = div_q == '0 && (!ctrl_q.quarter_resolution_mode || !h_q[0]);
      par = ctrl_q.quarter_resolution_mode ? h_q[1] : h_q[0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_q <= '0;
      end else if (pst) begin
         cur_q <= pix_i;
      end
   end

   // Byte selection per mode
   pix_s s;
   logic [7:0] c, ra, rb, b0, b1, b8, y16, uv16b, yb, code_b, xy, nbyte;
   logic hwin, vwin, qline, act, csav, ceav, code_hit, bsel;
   logic [9:0] hend;
   logic [1:0] cidx;

   always_comb begin
      s = pst ? pix_i : cur_q;
      c = (par ^ ctrl_q.uvs) ? s.v : s.u;
      ra = ctrl_q.uvs ? s.u : s.y;
      rb = ctrl_q.uvs ? s.y : s.u;
      if (rgb) begin
         b0 = par ? ra : rb;
         b1 = par ? rb : ra;
      end else begin
         b0 = ctrl_q.yus ? s.y : c;
         b1 = ctrl_q.yus ? c : s.y;
      end
      bsel = (slog == 2'd2) ? k[1] : k[0];
      b8 = ctrl_q.bw ? s.y : (bsel ? b1 : b0);
      y16 = (rgb && !ctrl_q.bw) ? ra : s.y;
      uv16b = rgb ? rb : c;
      hwin = h_q >= hwin_q.st && h_q < hwin_q.st + hwin_q.sz;
      vwin = v_q >= vwin_q.st && v_q < vwin_q.st + vwin_q.sz;
      qline = !ctrl_q.quarter_resolution_mode || !v_q[0];
      act = hwin && vwin && qline;
      hend = hwin_q.st + hwin_q.sz;
      // Codes sit in the two pixel slots on each side of the window
      csav = h_q == hwin_q.st - 10'h002 || h_q == hwin_q.st - 10'h001;
      ceav = h_q == hend || h_q == hend + 10'h001;
      code_hit = ctrl_q.fmt == F_RGB656 && vwin && qline && (csav || ceav);
      cidx = {h_q[0] ^ (csav ? hwin_q.st[0] : hend[0]), k[0]};
      xy = {1'b1, odd_q, 1'b0, ceav, ceav, odd_q ^ ceav, odd_q, odd_q ^ ceav};
      unique case (cidx)
         2'd0: code_b = 8'hFF;
         2'd3: code_b = xy;
         default: code_b = 8'h00;
      endcase
      nbyte = clip(b8);
      if (code_hit) begin
         yb = code_b;
      end else if (!act) begin
         yb = `BLANK_Y;
      end else if (nib) begin
         yb = {k[0] ? nbyte[3:0] : nbyte[7:4], 4'h0};
      end else if (slog == 2'd1 && !wide2) begin
         yb = nbyte;
      end else begin
         yb = clip(y16);
      end
   end

   // Everything the receiver samples moves at the falling pixel clock edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pclk <= 1'b0;
      end else if (sst) begin
         pclk <= 1'b0;
      end else if (rise) begin
         pclk <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         y_o <= 8'h00;
         uv_o <= 8'h00;
         line_valid <= 1'b0;
         vsync <= 1'b0;
         composite_line_sync <= 1'b0;
         odd_field_flag <= 1'b0;
         // A slot start that finds pclk still low (after reset, or when a mode write shortens the
         // slot) is skipped, so the bus only ever moves together with a falling pclk
      end else if (sst && pclk) begin
         y_o <= ctrl_q.rev ? {<<{yb}} : yb;
         uv_o <= act ? (ctrl_q.rev ? {<<{clip(uv16b)}} : clip(uv16b)) : `BLANK_UV;
         line_valid <= act;
         vsync <= v_q >= `VS_FIRST && v_q < `VS_LAST;
         composite_line_sync <= (h_q >= `HS_FIRST && h_q < `HS_LAST) ^ (v_q >= `VS_FIRST && v_q < `VS_LAST);
         odd_field_flag <= odd_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         y_oe <= 1'b0;
         uv_oe <= 1'b0;
         pix_req <= 1'b0;
      end else begin
         y_oe <= 1'b1;
         uv_oe <= uv16;
         pix_req <= pst;
      end
   end

   a_no_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
      (line_valid && !ctrl_q.fmt[2]) |-> (y_o != 8'h00 && y_o != 8'hFF && uv_o != 8'h00 && uv_o != 8'hFF))
      else $error("reserved code on data bus");

   a_data_on_fall: assert property (@(posedge hclk) disable iff (!hresetn)
      ($changed(y_o) || $changed(line_valid)) |-> (!pclk && $past(pclk)))
      else $error("data moved away from falling clock edge");

   a_rate_8bit: assert property (@(posedge hclk) disable iff (!hresetn)
      ($fell(pclk) && ctrl_q.fmt == F_YUV8 && !ctrl_q.bw && !ctrl_q.quarter_resolution_mode && $stable(ctrl_q))
      |-> ##SL1 $fell(pclk))
      else $error("8-bit clock not at twice pixel rate");

   a_uv_off_8bit: assert property (@(posedge hclk) disable iff (!hresetn)
      (eight && $past(eight)) |-> !uv_oe)
      else $error("UV driven in 8-bit mode");

   a_bw_uv_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(ctrl_q.bw) |-> !uv_oe)
      else $error("UV driven in mono mode");

   a_win_legal: assert property (@(posedge hclk) disable iff (!hresetn)
      hwin_q.sz >= `MIN_WIN && hwin_q.st + hwin_q.sz <= `ARR_W && vwin_q.st + vwin_q.sz <= `ARR_H)
      else $error("window outside array");

   a_rate_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
      (div_q == DIVM) |=> (h_q != $past(h_q)) ##1 (h_q == $past(h_q)))
      else $error("pixel position rate disturbed");

   a_sav_seq: assert property (@(posedge hclk) disable iff (!hresetn)
      (sst && code_hit && cidx == 2'd0 && !ctrl_q.quarter_resolution_mode && !ctrl_q.rev && $stable(ctrl_q))
      |=> (y_o == 8'hFF) ##SL1 (y_o == 8'h00))
      else $error("656 code sequence broken");
endmodule

/* File: sim/cam_capture_model.sv */
// Host capture model that samples the video bus at each rising pixel clock
`timescale 1ns/1ps
module cam_capture_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pclk,
   input wire logic [7:0] y_o,
   input wire logic [7:0] uv_o,
   input wire logic line_valid,
   output logic [7:0] y_cap [4],
   output logic [7:0] uv_cap [4],
   output logic [31:0] pre4,
   output int run_len,
   output int period,
   output int n_runs,
   output int n_bad
);
   logic pclk_q;
   int pos;
   int cyc;
   logic [31:0] hist;
   // Pixel clock edges are found in the hclk domain, as a capture chip would
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pclk_q <= 1'b0;
         pos <= 0;
         cyc <= 0;
         hist <= 32'h0000_0000;
         run_len <= 0;
         n_runs <= 0;
         n_bad <= 0;
      end else begin
         pclk_q <= pclk;
         cyc <= cyc + 1;
         if (pclk && !pclk_q) begin
            period <= cyc + 1;
            cyc <= 0;
            if (line_valid) begin
               if (pos == 0) pre4 <= hist;
               if (pos < 4) begin
                  y_cap[pos] <= y_o;
                  uv_cap[pos] <= uv_o;
               end
               pos <= pos + 1;
               if (y_o == 8'h00 || y_o == 8'hFF) n_bad <= n_bad + 1;
            end else begin
               hist <= {hist[23:0], y_o};
               if (pos != 0) begin
                  run_len <= pos;
                  n_runs <= n_runs + 1;
                  pos <= 0;
               end
            end
         end
      end
   end
endmodule

/* File: sim/tb_top.sv */
// Bench for the video output formatter: register access and output formats
`timescale 1ns/1ps
`include "cam_fmt_cfg.svh"
module tb_top
   import cam_fmt_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready, hresp, pix_req, pclk, y_oe, uv_oe, line_valid, vsync, csync, odd;
   logic [31:0] hrdata, pre4;
   logic [7:0] y_o, uv_o;
   logic [7:0] y_cap [4];
   logic [7:0] uv_cap [4];
   pix_s pix_i = '{y: 8'h40, u: 8'h50, v: 8'h60};
   int run_len, period, n_runs, n_bad, i;
   int n_fail = 0;
   int checks = 0;
   always #5 hclk = ~hclk;
   // Short raster keeps a line near 3200 cycles
   cam_video_formatter #(.BASE_DIV(8), .H_TOTAL(10'h193), .V_TOTAL(10'h12F)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .pix_i(pix_i), .pix_req(pix_req), .pclk(pclk),
      .y_o(y_o), .y_oe(y_oe), .uv_o(uv_o), .uv_oe(uv_oe), .line_valid(line_valid),
      .vsync(vsync), .composite_line_sync(csync), .odd_field_flag(odd));
   cam_capture_model cap (
      .hclk(hclk), .hresetn(hresetn), .pclk(pclk), .y_o(y_o), .uv_o(uv_o),
      .line_valid(line_valid), .y_cap(y_cap), .uv_cap(uv_cap), .pre4(pre4),
      .run_len(run_len), .period(period), .n_runs(n_runs), .n_bad(n_bad));
   task automatic print_verdict();
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      int k;
      k = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 100);
      r = hrdata;
      if (k >= 100) begin
         n_fail++;
         print_verdict();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(a, 1'b0, 32'h0000_0000, r);
      chk(r, e);
   endtask
   // A capture run ends just past the window, so the next write lands outside it
   task automatic mode(input logic [31:0] c, input int len, input int per, input logic oe,
      input logic [31:0] ey, input logic [31:0] eu);
      int r0;
      int k;
      wr(`A_CTRL, c);
      r0 = n_runs;
      k = 0;
      while (n_runs == r0 && k < 30000) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 30000) begin
         n_fail++;
         print_verdict();
      end
      chk(run_len, len);
      chk(period, per);
      chk(uv_oe, oe);
      for (int j = 0; j < 4 && j < len; j++) begin
         if (ey != 0) chk(y_cap[j], ey[31-8*j -: 8]);
         if (oe && eu != 0) chk(uv_cap[j], eu[31-8*j -: 8]);
      end
   endtask
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(`A_CTRL, 32'h0000_0000);
      rdc(`A_WIN_H, 32'h0160_0002);
      rdc(`A_WIN_V, 32'h0120_0002);
      rdc(8'h10, 32'h0000_0000);
      chk(hresp, 1'b0);
      chk(y_oe, 1'b1);
      mode(32'h0000_0000, 352, 8, 1'b1, 32'h4040_4040, 32'h5060_5060);
      i = 0;
      while (csync !== 1'b1 && i < 4000) begin
         @(posedge hclk);
         i++;
      end
      chk(csync, 1'b1);
      wr(`A_WIN_H, 32'h0001_03FF);
      rdc(`A_WIN_H, 32'h0002_0162);
      wr(`A_WIN_H, 32'h0004_0004);
      rdc(`A_WIN_H, 32'h0004_0004);
      pix_i.y <= 8'hFF;
      mode(32'h0000_0000, 4, 8, 1'b1, 32'hFEFE_FEFE, 32'h5060_5060);
      pix_i.y <= 8'h40;
      mode(32'h0000_0001, 8, 4, 1'b0, 32'h5040_6040, 32'h0000_0000);
      mode(32'h0000_0041, 8, 4, 1'b0, 32'h6040_5040, 32'h0000_0000);
      mode(32'h0000_0081, 8, 4, 1'b0, 32'h4050_4060, 32'h0000_0000);
      mode(32'h0000_0040, 4, 8, 1'b1, 32'h4040_4040, 32'h6050_6050);
      mode(32'h0000_0100, 4, 8, 1'b1, 32'h0202_0202, 32'h0A06_0A06);
      mode(32'h0000_0006, 4, 8, 1'b1, 32'h4040_4040, 32'h5050_5050);
      mode(32'h0000_0046, 4, 8, 1'b1, 32'h5050_5050, 32'h4040_4040);
      mode(32'h0000_0008, 4, 8, 1'b0, 32'h4040_4040, 32'h0000_0000);
      mode(32'h0000_0020, 8, 4, 1'b1, 32'h4040_4040, 32'h5050_6060);
      mode(32'h0000_0010, 2, 16, 1'b1, 32'h4040_4040, 32'h0000_0000);
      mode(32'h0000_0003, 8, 4, 1'b0, 32'h0000_0000, 32'h0000_0000);
      chk(n_bad, 32'h0000_0000);
      mode(32'h0000_0002, 8, 4, 1'b0, 32'h0000_0000, 32'h0000_0000);
      chk(pre4, {24'hFF_0000, odd ? 8'hC7 : 8'h80});
      mode(32'h0000_0007, 16, 2, 1'b0, 32'h0000_0000, 32'h0000_0000);
      mode(32'h0000_000F, 8, 4, 1'b0, 32'h0000_0000, 32'h0000_0000);
      print_verdict();
   end
endmodule
